// ==== include/dps_pkg.sv ====
// constants and types for the dual-port sram port host controller
// Function
// - hold strobes high while address changes
// - select held twelve ns before write end
// - write pulse long enough for turnoff plus setup
// - never drive data while device drives
// - flag write then read keeps chip deselected
// - write recovery of zero ns observed
// - flag update needs ten ns high pulse
// - opposite port flag writes five ns apart
// - write data held through end of write
package dps_pkg;

  localparam int CLK_NS      = 100;
  localparam int SYNC_STAGES = 2;

  // timing figures, slower grade so either part works
  localparam int T_WP_NS   = 15;
  localparam int T_AA_NS   = 20;
  localparam int T_ACE_NS  = 20;
  localparam int T_AOE_NS  = 12;
  localparam int T_BDD_NS  = 17;
  localparam int T_SOP_NS  = 10;
  localparam int T_SWRD_NS = 5;
  localparam int T_CYC_NS  = 20;

  // least times round up, never below one cycle
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    if (c < 1) begin
      c = 1;
    end
    return c;
  endfunction : ceil_cyc

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : max2

  localparam int T_RD_NS = max2(max2(T_AA_NS, T_ACE_NS), max2(T_AOE_NS, T_BDD_NS));

  localparam logic [3:0] WP_CYC    = 4'(max2(ceil_cyc(T_WP_NS), ceil_cyc(T_CYC_NS)));
  localparam logic [3:0] RD_CYC    = 4'(max2(ceil_cyc(T_RD_NS), ceil_cyc(T_CYC_NS)) + SYNC_STAGES);
  localparam logic [3:0] RECOV_CYC = 4'(max2(ceil_cyc(T_SOP_NS), ceil_cyc(T_SWRD_NS)));

  // register map
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_ADDR  = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STAT  = 8'h10;

  // field positions
  localparam int CTRL_GO    = 0;
  localparam int CTRL_OP    = 1;
  localparam int CTRL_LLANE = 3;
  localparam int CTRL_HLANE = 4;
  localparam int STAT_BUSY  = 0;
  localparam int STAT_DONE  = 1;
  localparam int STAT_UNIF  = 2;

  // reset values
  localparam logic [1:0]  RST_LANES = 2'h3;
  localparam logic [15:0] RST_ADDR  = 16'h0000;
  localparam logic [17:0] RST_DATA  = 18'h00000;

  typedef enum logic [1:0] {
    OP_ARR_RD,
    OP_ARR_WR,
    OP_SEM_WR,
    OP_SEM_RD
  } dps_op_t;

endpackage : dps_pkg

// ==== src/dps_sync.sv ====
// two-stage synchroniser for the data pins
`timescale 1ns/1ns
`default_nettype none
module dps_sync #(
  parameter int W = 18
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // data
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : dps_sync
`default_nettype wire

// ==== src/dps_host.sv ====
// host controller driving one port of the dual-port sram, apb slave
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module dps_host (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output var  logic [31:0]        prdata,
  output var  logic               pready,
  output var  logic               pslverr,
  // sram port controls
  output var  logic [15:0]        sram_addr,
  output var  logic               sram_cs_n,
  output var  logic               sram_we_n,
  output var  logic               sram_oe_n,
  output var  logic               flag_space_select_n,
  output var  logic               high_lane_select_n,
  output var  logic               low_lane_select_n,
  // sram data pins
  output var  logic [17:0]        sram_dq_o,
  output var  logic               sram_dq_oe,
  input  wire logic [17:0]        sram_dq_i
);
  import dps_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_PULSE,
    ST_TAIL,
    ST_RECOV
  } dps_st_t;

  dps_st_t     st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;
  dps_op_t     op_q;
  logic [1:0]  lanes_q;
  logic [15:0] addr_q;
  logic [17:0] wdat_q, rdat_q, dq_s;
  logic        done_q, unif_q;
  logic        acc, wr_fire, go, mapped;
  logic        is_wr, is_sem, is_rd;
  logic        sel, drv;

  function automatic logic op_is_sem(input dps_op_t op);
    return (op == OP_SEM_WR) || (op == OP_SEM_RD);
  endfunction : op_is_sem

  ////////////////////////////////////////////////////////////////
  // apb slave: one wait state, answer from flops

  assign acc     = psel & penable;
  assign wr_fire = acc & pwrite & pready;
  assign mapped  = (paddr == REG_CTRL) || (paddr == REG_ADDR) || (paddr == REG_WDATA)
                || (paddr == REG_RDATA) || (paddr == REG_STAT);
  assign go      = wr_fire && (paddr == REG_CTRL) && pwdata[CTRL_GO] && (st_q == ST_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= acc && !pready;
      pslverr <= acc && !pready && !mapped;
      if (acc && !pready) begin
        case (paddr)
          REG_CTRL:  prdata <= {27'h0, lanes_q, op_q, 1'b0};
          REG_ADDR:  prdata <= {16'h0, addr_q};
          REG_WDATA: prdata <= {14'h0, wdat_q};
          REG_RDATA: prdata <= {14'h0, rdat_q};
          REG_STAT:  prdata <= {29'h0, unif_q, done_q, st_q != ST_IDLE};
          default:   prdata <= 32'h0;
        endcase
      end
    end
  end

  // settings frozen while a cycle runs so pins stay stable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q    <= OP_ARR_RD;
      lanes_q <= RST_LANES;
      addr_q  <= RST_ADDR;
      wdat_q  <= RST_DATA;
    end else if (wr_fire && st_q == ST_IDLE) begin
      if (paddr == REG_CTRL) begin
        op_q    <= dps_op_t'(pwdata[CTRL_OP +: 2]);
        lanes_q <= {pwdata[CTRL_HLANE], pwdata[CTRL_LLANE]};
      end
      if (paddr == REG_ADDR) begin
        addr_q <= pwdata[15:0];
      end
      if (paddr == REG_WDATA) begin
        wdat_q <= pwdata[17:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin cycle sequencer

  assign is_wr  = (op_q == OP_ARR_WR) || (op_q == OP_SEM_WR);
  assign is_sem = op_is_sem(op_q);
  assign is_rd  = !is_wr;

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      ST_IDLE: begin
        if (go) begin
          st_d = ST_SETUP;
        end
      end
      ST_SETUP: begin
        st_d  = ST_PULSE;
        cnt_d = is_rd ? RD_CYC - 4'h1 : WP_CYC - 4'h1;
      end
      ST_PULSE: begin
        if (cnt_q == 4'h0) begin
          st_d  = is_rd ? ST_RECOV : ST_TAIL;
          cnt_d = RECOV_CYC - 4'h1;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      ST_TAIL: begin
        st_d  = ST_RECOV;
        cnt_d = RECOV_CYC - 4'h1;
      end
      ST_RECOV: begin
        if (cnt_q == 4'h0) begin
          // this port's flag writes are always spaced by recovery and setup
          st_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      default: begin
        st_d  = ST_IDLE;
        cnt_d = 4'h0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q  <= ST_IDLE;
      cnt_q <= 4'h0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // pins registered from the next state

  assign sel = (st_d == ST_PULSE);
  assign drv = is_wr && ((st_d == ST_PULSE) || (st_d == ST_TAIL));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sram_addr           <= RST_ADDR;
      sram_cs_n           <= 1'b1;
      sram_we_n           <= 1'b1;
      sram_oe_n           <= 1'b1;
      flag_space_select_n <= 1'b1;
      high_lane_select_n  <= 1'b1;
      low_lane_select_n   <= 1'b1;
      sram_dq_o           <= RST_DATA;
      sram_dq_oe          <= 1'b0;
    end else begin
      // address moves only on entry to setup, strobes high
      if (st_d == ST_SETUP) begin
        // op register loads on this same edge, so decode the incoming op
        sram_addr <= op_is_sem(dps_op_t'(pwdata[CTRL_OP +: 2])) ? {13'h0, addr_q[2:0]} : addr_q;
      end
      // select and strobe fall together, so outputs stay released
      sram_cs_n           <= !(sel && !is_sem);
      flag_space_select_n <= !(sel && is_sem);
      sram_we_n           <= !(sel && is_wr);
      // output enable stays high in writes: no bus fight
      sram_oe_n           <= !(sel && is_rd);
      high_lane_select_n  <= !(sel && !is_sem && lanes_q[1]);
      low_lane_select_n   <= !(sel && !is_sem && lanes_q[0]);
      sram_dq_oe          <= drv;
      sram_dq_o           <= is_sem ? {17'h0, wdat_q[0]} : wdat_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // read capture and status

  dps_sync #(
    .W (18)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (sram_dq_i),
    .q       (dq_s)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdat_q <= RST_DATA;
      unif_q <= 1'b0;
    end else if (st_q == ST_PULSE && cnt_q == 4'h0 && is_rd) begin
      // sampled after slowest access plus synchroniser depth
      rdat_q <= dq_s;
      // a flag read must repeat on all lines; the uniform bit is set only on a match
      unif_q <= is_sem ? ((&dq_s) || !(|dq_s)) : 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else if (st_q == ST_RECOV && st_d == ST_IDLE) begin
      done_q <= 1'b1;
    end else if (go) begin
      done_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks

  logic [3:0] wlow_q;
  logic [3:0] shi_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wlow_q <= 4'h0;
      shi_q  <= 4'h0;
    end else begin
      wlow_q <= !sram_we_n ? wlow_q + 4'h1 : 4'h0;
      shi_q  <= (flag_space_select_n && shi_q != 4'hf) ? shi_q + 4'h1 : (flag_space_select_n ? shi_q : 4'h0);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_addr_stable;
    $changed(sram_addr) |-> (sram_we_n && $past(sram_we_n)) && (sram_cs_n && $past(sram_cs_n));
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved under strobe");

  property p_sel_at_end;
    $rose(sram_we_n) |-> $past(!sram_cs_n || !flag_space_select_n) && (wlow_q == WP_CYC);
  endproperty
  a_sel_at_end: assert property (p_sel_at_end) else $error("select not held to write end");

  property p_pulse_width;
    $fell(sram_we_n) |-> !sram_we_n [*1] ##0 (wlow_q == 4'h0) ##1 (wlow_q == 4'h1);
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("write pulse too short");

  property p_no_fight;
    sram_dq_oe |-> sram_oe_n && $past(sram_oe_n);
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("data driven with output enable low");

  property p_sem_deselect;
    !flag_space_select_n |-> sram_cs_n && high_lane_select_n && low_lane_select_n;
  endproperty
  a_sem_deselect: assert property (p_sem_deselect) else $error("chip selected in flag access");

  property p_recovery;
    $rose(sram_we_n) |-> sram_cs_n && flag_space_select_n ##1 sram_we_n && sram_cs_n;
  endproperty
  a_recovery: assert property (p_recovery) else $error("no recovery after write");

  property p_flag_pulse;
    $fell(flag_space_select_n) |-> $past(shi_q) >= RECOV_CYC;
  endproperty
  a_flag_pulse: assert property (p_flag_pulse) else $error("flag select high too briefly");

  property p_data_hold;
    $rose(sram_we_n) |-> sram_dq_oe && $stable(sram_dq_o);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("write data dropped at write end");

  property p_cycle_len;
    $fell(sram_oe_n) |-> !sram_oe_n [*3];
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("read cycle too short");

  c_arr_wr: cover property ($rose(sram_we_n) && !$past(sram_cs_n));
  c_sem_wr: cover property ($rose(sram_we_n) && !$past(flag_space_select_n));
  c_arr_rd: cover property ($rose(sram_oe_n) && !$past(sram_cs_n));
  c_sem_rd: cover property ($rose(sram_oe_n) && !$past(flag_space_select_n) && unif_q);

endmodule : dps_host
`default_nettype wire

// ==== verification/dps_mem_model.sv ====
// behavioural model of one port of the dual-port sram
`timescale 1ns/1ns
`default_nettype none
module dps_mem_model (
  // clock for the floating-line pattern
  input  wire logic        clk,
  // port controls
  input  wire logic [15:0] addr,
  input  wire logic        cs_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        flag_n,
  input  wire logic        hl_n,
  input  wire logic        ll_n,
  // data pins
  input  wire logic [17:0] host_dq,
  input  wire logic        host_oe,
  output var  logic [17:0] dq,
  output var  logic        dev_drv
);
  logic [17:0] mem [0:65535];
  logic [7:0]  flag = 8'hff;
  logic [17:0] last = 18'h00000;
  logic [17:0] rdv;
  logic [17:0] msk;
  ////////////////////////////////////////////////////////////////////////////
  // data valid at once; released lines show the inverse of the last level
  assign dev_drv = we_n && !oe_n && (!flag_n || (!cs_n && !(hl_n && ll_n)));
  assign rdv     = !flag_n ? {18{flag[addr[2:0]]}} : mem[addr];
  assign msk     = !dev_drv ? 18'h00000 : (!flag_n ? 18'h3ffff : {{9{!hl_n}}, {9{!ll_n}}});
  assign dq      = host_oe ? host_dq : ((msk & rdv) | (~msk & ~last));
  always @(posedge clk) last <= dq;
  ////////////////////////////////////////////////////////////////////////////
  // one port only, so a flag write is always granted
  always @(posedge clk) begin
    if (!we_n && !cs_n && !ll_n) mem[addr][8:0] <= dq[8:0];
    if (!we_n && !cs_n && !hl_n) mem[addr][17:9] <= dq[17:9];
    if (!we_n && !flag_n) flag[addr[2:0]] <= dq[0];
  end
endmodule : dps_mem_model
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the sram port host controller
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dps_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rv;
  logic        pready, pslverr, re;
  logic [15:0] sram_addr, ap;
  logic        cs_n, we_n, oe_n, fl_n, hl_n, ll_n, dq_oe, dev_drv;
  logic [17:0] dq_o, dq;
  int          failures = 0;
  int          checked = 0;
  int          cyc = 0;
  always #50 pclk = ~pclk;
  dps_host u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sram_addr(sram_addr), .sram_cs_n(cs_n), .sram_we_n(we_n), .sram_oe_n(oe_n),
    .flag_space_select_n(fl_n), .high_lane_select_n(hl_n), .low_lane_select_n(ll_n),
    .sram_dq_o(dq_o), .sram_dq_oe(dq_oe), .sram_dq_i(dq));
  dps_mem_model u_mem (.clk(pclk), .addr(sram_addr), .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n),
    .flag_n(fl_n), .hl_n(hl_n), .ll_n(ll_n), .host_dq(dq_o), .host_oe(dq_oe), .dq(dq), .dev_drv(dev_drv));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task close_out;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  // request held until pready is seen high at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task cmd(input dps_op_t op, input logic [1:0] l);
    int n;
    apb(1'b1, REG_CTRL, {27'h0, l, op, 1'b1});
    n = 0;
    do begin
      apb(1'b0, REG_STAT, 32'h0);
      n++;
    end while (rv[STAT_DONE] !== 1'b1 && n < 30);
    chk({31'h0, rv[STAT_DONE]}, 32'h1);
  endtask : cmd
  function automatic logic [17:0] merge(input logic [17:0] o, input logic [17:0] n, input logic [1:0] l);
    return {l[1] ? n[17:9] : o[17:9], l[0] ? n[8:0] : o[8:0]};
  endfunction : merge
  ////////////////////////////////////////////////////////////////////////////
  // pin monitor; address moves only with no array write strobed
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out;
    end
    if (presetn && sram_addr !== ap) chk({31'h0, we_n | cs_n | (hl_n & ll_n)}, 32'h1);
    if (presetn) chk({31'h0, cs_n | fl_n}, 32'h1);
    if (presetn && !fl_n) chk({16'h0, sram_addr & 16'hfff8}, 32'h0);
    if (presetn && dev_drv) chk({31'h0, dq_oe}, 32'h0);
    ap <= sram_addr;
  end
  initial begin
    int          seed;
    logic [15:0] a;
    logic [17:0] d, d2;
    logic [7:0]  fb;
    seed = 25;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rv & 32'h19, 32'h18);
    apb(1'b0, REG_STAT, 32'h0);
    chk(rv, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk({rv[30:0], re}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($random(seed));
      d = 18'($random(seed));
      d2 = 18'($random(seed));
      apb(1'b1, REG_ADDR, {16'h0, a});
      apb(1'b1, REG_WDATA, {14'h0, d});
      cmd(OP_ARR_WR, 2'b11);
      apb(1'b1, REG_WDATA, {14'h0, d2});
      cmd(OP_ARR_WR, 2'(i));
      cmd(OP_ARR_RD, 2'b11);
      apb(1'b0, REG_RDATA, 32'h0);
      chk(rv, {14'h0, merge(d, d2, 2'(i))});
    end
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, REG_ADDR, {16'h0, 13'($random(seed)), 3'(i)});
      if (i < 8) fb[i] = 1'($random(seed));
      if (i < 8) apb(1'b1, REG_WDATA, {31'($random(seed)), fb[i]});
      if (i < 8) cmd(OP_SEM_WR, 2'b11);
      cmd(OP_SEM_RD, 2'b11);
      apb(1'b0, REG_RDATA, 32'h0);
      chk(rv, {14'h0, {18{fb[i%8]}}});
      apb(1'b0, REG_STAT, 32'h0);
      chk({31'h0, rv[STAT_UNIF]}, 32'h1);
    end
    apb(1'b1, REG_ADDR, 32'h00000007);
    apb(1'b1, REG_WDATA, 32'h00012a5c);
    cmd(OP_ARR_WR, 2'b11);
    apb(1'b1, REG_CTRL, {27'h0, 2'b11, OP_ARR_RD, 1'b1});
    apb(1'b1, REG_ADDR, 32'h00001234);
    cmd(OP_ARR_RD, 2'b11);
    apb(1'b0, REG_ADDR, 32'h0);
    chk(rv, 32'h00000007);
    apb(1'b1, REG_RDATA, 32'h0003ffff);
    apb(1'b0, REG_RDATA, 32'h0);
    chk(rv, 32'h00012a5c);
    close_out;
  end
endmodule : tb
`default_nettype wire
